// ==== src/ctrl_supervisor_pkg.sv ====
package ctrl_supervisor_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] MANUAL_MV_OFS = 8'h04;
  localparam logic [7:0] SETPOINT_OFS  = 8'h08;
  localparam logic [7:0] PBAND_OFS     = 8'h0c;
  localparam logic [7:0] ITIME_OFS     = 8'h10;
  localparam logic [7:0] DTIME_OFS     = 8'h14;
  localparam logic [7:0] RT_LOW_OFS    = 8'h18;
  localparam logic [7:0] RT_HIGH_OFS   = 8'h1c;
  localparam logic [7:0] SAFE_OFS      = 8'h20;
  localparam logic [7:0] ALM1_SP_OFS   = 8'h24;
  localparam logic [7:0] ALM2_SP_OFS   = 8'h28;
  localparam logic [7:0] ALM_FUNC_OFS  = 8'h2c;
  localparam logic [7:0] CHAN_OFS      = 8'h30;
  localparam logic [7:0] LB_INT_OFS    = 8'h34;
  localparam logic [7:0] STATUS_OFS    = 8'h38;
  // control register fields
  localparam int unsigned CTRL_AUTO_BIT   = 0;
  localparam int unsigned CTRL_RANGE0_BIT = 1;
  localparam int unsigned CTRL_AFUNC_LSB  = 2;
  localparam int unsigned CTRL_BLOCK_LSB  = 4;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0030;
  localparam logic [31:0] CHAN_RESET      = 32'h0000_0000;
  localparam int unsigned ALM_FUNC_W      = 3;
  localparam int unsigned ALM_FUNC_STRIDE = 4;
  localparam int unsigned CHAN_SEL_W      = 3;
  localparam int unsigned CHAN_STRIDE     = 4;
  localparam int unsigned STAT_FAULT_BIT  = 3;
  localparam int unsigned STAT_ONOFF_BIT  = 4;
  localparam int unsigned STAT_MV_LSB     = 8;
  // analog output functions
  localparam logic [1:0] AOUT_CONTROL = 2'h0;
  localparam logic [1:0] AOUT_PV      = 2'h1;
  localparam logic [1:0] AOUT_SP      = 2'h2;
  // alarm functions
  localparam logic [2:0] ALM_OFF      = 3'h0;
  localparam logic [2:0] ALM_UNDER    = 3'h1;
  localparam logic [2:0] ALM_OVER     = 3'h2;
  localparam logic [2:0] ALM_DEV      = 3'h3;
  localparam logic [2:0] ALM_DEV_HIGH = 3'h4;
  localparam logic [2:0] ALM_OPEN     = 3'h5;
  // channel sources
  localparam logic [2:0] SRC_CONTROL  = 3'h0;
  localparam logic [2:0] SRC_ALARM1   = 3'h1;
  localparam logic [2:0] SRC_ALARM2   = 3'h2;
  localparam logic [2:0] SRC_EITHER   = 3'h3;
  localparam logic [2:0] SRC_LOOPBRK  = 3'h4;
  // levels
  localparam logic [6:0]  MV_FULL      = 7'h64;
  localparam logic [6:0]  MV_NONE      = 7'h00;
  localparam logic [14:0] UA_FULL      = 15'h4e20;
  localparam logic [14:0] UA_LIVE_ZERO = 15'h0fa0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // timing
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned MINUTE_S          = 60;
  localparam int unsigned CYCLES_PER_MINUTE = MINUTE_S * CLK_HZ;
  localparam int unsigned PWM_STEP_CYCLES   = 20_000;
endpackage

// ==== src/ctrl_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctrl_supervisor
  import ctrl_supervisor_pkg::*;
#(
  parameter int unsigned MINUTE_CYCLES = CYCLES_PER_MINUTE,
  parameter int unsigned STEP_CYCLES   = PWM_STEP_CYCLES,
  parameter int unsigned CHANNELS      = 4,
  parameter logic [15:0] PV_MOVE_DELTA = 16'h000a
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic                  awvalid,
  output var  logic                  awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output var  logic                  wready,
  output var  logic [1:0]            bresp,
  output var  logic                  bvalid,
  input  wire logic                  bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic                  arvalid,
  output var  logic                  arready,
  output var  logic [31:0]           rdata,
  output var  logic [1:0]            rresp,
  output var  logic                  rvalid,
  input  wire logic                  rready,
  // process side
  input  wire logic signed [15:0]    pv,
  input  wire logic [6:0]            pid_mv,
  input  wire logic                  sensor_fault,
  // pid engine parameters
  output var  logic [15:0]           proportional_band,
  output var  logic [15:0]           integral_time,
  output var  logic [15:0]           derivative_time,
  // outputs
  output var  logic [CHANNELS-1:0]   channel_out,
  output var  logic [14:0]           analog_ua,
  output var  logic [6:0]            mv_percent,
  output var  logic                  loop_break_event
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return 16'(merge({16'h0, old}, d, s));
  endfunction

  // registers
  logic [31:0]        ctrl;
  logic [6:0]         manual_mv;
  logic signed [15:0] setpoint;
  logic signed [15:0] retrans_low_limit;
  logic signed [15:0] retrans_high_limit;
  logic [6:0]         sensor_fault_output_level;
  logic signed [15:0] alarm_sp [2];
  logic [31:0]        alarm_func_reg;
  logic [31:0]        chan_reg;
  logic [15:0]        loop_break_interval;
  logic [1:0]         alarm_out;

  // bus handshake state
  logic               aw_have;
  logic               w_have;
  logic [ADDR_W-1:0]  waddr;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               aw_hs;
  logic               w_hs;
  logic               ar_hs;
  logic               do_write;
  logic               wr_ok;
  logic               rd_ok;
  logic [31:0]        rd_word;

  assign aw_hs    = awvalid & awready;
  assign w_hs     = wvalid & wready;
  assign ar_hs    = arvalid & arready;
  assign do_write = aw_have & w_have & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      awready <= 1'b0;
      waddr   <= '0;
    end else begin
      if (do_write) begin
        aw_have <= 1'b0;
      end else if (aw_hs) begin
        aw_have <= 1'b1;
        waddr   <= awaddr;
      end
      awready <= do_write | ~(aw_have | aw_hs);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have  <= 1'b0;
      wready  <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (do_write) begin
        w_have <= 1'b0;
      end else if (w_hs) begin
        w_have  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      wready <= do_write | ~(w_have | w_hs);
    end
  end

  always_comb begin
    case (waddr)
      CTRL_OFS, MANUAL_MV_OFS, SETPOINT_OFS, PBAND_OFS, ITIME_OFS, DTIME_OFS,
      RT_LOW_OFS, RT_HIGH_OFS, SAFE_OFS, ALM1_SP_OFS, ALM2_SP_OFS, ALM_FUNC_OFS,
      CHAN_OFS, LB_INT_OFS: wr_ok = 1'b1;
      default:              wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                      <= CTRL_RESET;
      manual_mv                 <= MV_NONE;
      setpoint                  <= '0;
      proportional_band         <= '0;
      integral_time             <= '0;
      derivative_time           <= '0;
      retrans_low_limit         <= '0;
      retrans_high_limit        <= '0;
      sensor_fault_output_level <= MV_NONE;
      alarm_sp[0]               <= '0;
      alarm_sp[1]               <= '0;
      alarm_func_reg            <= '0;
      chan_reg                  <= CHAN_RESET;
      loop_break_interval       <= '0;
    end else if (do_write) begin
      case (waddr)
        CTRL_OFS:      ctrl <= merge(ctrl, wdata_q, wstrb_q);
        MANUAL_MV_OFS: manual_mv <= (wdata_q[6:0] > MV_FULL) ? MV_FULL : wdata_q[6:0];
        SETPOINT_OFS:  setpoint <= merge16(setpoint, wdata_q, wstrb_q);
        PBAND_OFS:     proportional_band <= merge16(proportional_band, wdata_q, wstrb_q);
        ITIME_OFS:     integral_time <= merge16(integral_time, wdata_q, wstrb_q);
        DTIME_OFS:     derivative_time <= merge16(derivative_time, wdata_q, wstrb_q);
        RT_LOW_OFS:    retrans_low_limit <= merge16(retrans_low_limit, wdata_q, wstrb_q);
        RT_HIGH_OFS:   retrans_high_limit <= merge16(retrans_high_limit, wdata_q, wstrb_q);
        SAFE_OFS:      sensor_fault_output_level <= (wdata_q[6:0] > MV_FULL) ? MV_FULL : wdata_q[6:0];
        ALM1_SP_OFS:   alarm_sp[0] <= merge16(alarm_sp[0], wdata_q, wstrb_q);
        ALM2_SP_OFS:   alarm_sp[1] <= merge16(alarm_sp[1], wdata_q, wstrb_q);
        ALM_FUNC_OFS:  alarm_func_reg <= merge(alarm_func_reg, wdata_q, wstrb_q);
        CHAN_OFS:      chan_reg <= merge(chan_reg, wdata_q, wstrb_q);
        LB_INT_OFS:    loop_break_interval <= merge16(loop_break_interval, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // sensor fault pin synchroniser
  logic fault_meta;
  logic fault;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_meta <= 1'b0;
      fault      <= 1'b0;
    end else begin
      fault_meta <= sensor_fault;
      fault      <= fault_meta;
    end
  end

  // control value selection
  logic       auto_mode;
  logic       onoff;
  logic [6:0] pid_clamped;
  logic [6:0] safe_mv;
  logic [6:0] next_mv;
  assign auto_mode   = ctrl[CTRL_AUTO_BIT];
  assign onoff       = proportional_band == 16'h0000;
  assign pid_clamped = (pid_mv > MV_FULL) ? MV_FULL : pid_mv;
  assign safe_mv     = (auto_mode && onoff) ?
                       ((sensor_fault_output_level == MV_FULL) ? MV_FULL : MV_NONE) :
                       sensor_fault_output_level;

  always_comb begin
    if (fault) begin
      next_mv = safe_mv;
    end else if (!auto_mode) begin
      next_mv = manual_mv;
    end else if (onoff) begin
      next_mv = (pv < setpoint) ? MV_FULL : MV_NONE;
    end else begin
      next_mv = pid_clamped;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mv_percent <= MV_NONE;
    end else begin
      mv_percent <= next_mv;
    end
  end

  // time proportioning of mv onto the switching outputs
  logic [31:0] step_cnt;
  logic [6:0]  step;
  logic        ctrl_on;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt <= '0;
      step     <= '0;
    end else if (step_cnt >= STEP_CYCLES - 1) begin
      step_cnt <= '0;
      step     <= (step >= MV_FULL - 7'h01) ? 7'h00 : step + 7'h01;
    end else begin
      step_cnt <= step_cnt + 32'h1;
    end
  end
  assign ctrl_on = step < mv_percent;

  // analog output
  logic [14:0] ua_base;
  logic [31:0] ua_span;
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] frac;
  logic signed [16:0] rt_val;
  logic signed [16:0] rt_lo;
  logic signed [16:0] rt_hi;
  logic [14:0] next_ua;
  assign ua_base = ctrl[CTRL_RANGE0_BIT] ? 15'h0000 : UA_LIVE_ZERO;
  assign ua_span = {17'h0, UA_FULL - ua_base};

  always_comb begin
    rt_lo = 17'(retrans_low_limit);
    rt_hi = 17'(retrans_high_limit);
    rt_val = (ctrl[CTRL_AFUNC_LSB +: 2] == AOUT_SP) ? 17'(setpoint) : 17'(pv);
    if (rt_val < rt_lo) begin
      rt_val = rt_lo;
    end else if (rt_val > rt_hi) begin
      rt_val = rt_hi;
    end
    if (ctrl[CTRL_AFUNC_LSB +: 2] == AOUT_CONTROL) begin
      num = {25'h0, mv_percent} * ua_span;
      den = {25'h0, MV_FULL};
    end else begin
      num = 32'(rt_val - rt_lo) * ua_span;
      den = (rt_hi > rt_lo) ? 32'(rt_hi - rt_lo) : 32'h1;
    end
    frac = num / den;
    if (ctrl[CTRL_AFUNC_LSB +: 2] != AOUT_CONTROL && !(rt_hi > rt_lo)) begin
      frac = '0;
    end
    next_ua = ua_base + frac[14:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_ua <= 15'h0000;
    end else begin
      analog_ua <= next_ua;
    end
  end

  // alarms
  logic func_write;
  assign func_write = do_write && waddr == ALM_FUNC_OFS;

  genvar a;
  generate
    for (a = 0; a < 2; a++) begin : g_alarm
      logic [2:0]         fn;
      logic signed [17:0] dev;
      logic signed [17:0] band;
      logic               cond;
      logic               armed;
      assign fn   = alarm_func_reg[a*ALM_FUNC_STRIDE +: ALM_FUNC_W];
      assign dev  = 18'(pv) - 18'(setpoint);
      assign band = 18'(alarm_sp[a]);

      always_comb begin
        case (fn)
          ALM_UNDER:    cond = pv < alarm_sp[a];
          ALM_OVER:     cond = (pv > alarm_sp[a]) | fault;
          ALM_DEV:      cond = (dev > band) | (-dev > band) | fault;
          ALM_DEV_HIGH: cond = (dev > band) | fault;
          ALM_OPEN:     cond = fault;
          default:      cond = 1'b0;
        endcase
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          armed <= 1'b0;
        end else if (func_write) begin
          armed <= 1'b0;
        end else if (!ctrl[CTRL_BLOCK_LSB + a] || !cond) begin
          armed <= 1'b1;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          alarm_out[a] <= 1'b0;
        end else if (fn == ALM_OPEN) begin
          alarm_out[a] <= fault;
        end else begin
          alarm_out[a] <= cond & armed & (fn != ALM_OFF);
        end
      end
    end
  endgenerate

  // loop break detection
  logic [31:0]        minute_cnt;
  logic [15:0]        minutes;
  logic signed [15:0] pv_ref;
  logic               saturated;
  logic               moved;
  logic               lb_idle;
  assign saturated = auto_mode && !fault && (mv_percent == MV_FULL || mv_percent == MV_NONE);
  assign moved = (mv_percent == MV_FULL) ? (pv >= pv_ref + $signed(PV_MOVE_DELTA)) :
                                           (pv <= pv_ref - $signed(PV_MOVE_DELTA));
  assign lb_idle = !saturated || moved || loop_break_interval == 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      minute_cnt       <= '0;
      minutes          <= '0;
      pv_ref           <= '0;
      loop_break_event <= 1'b0;
    end else if (lb_idle) begin
      minute_cnt       <= '0;
      minutes          <= '0;
      pv_ref           <= pv;
      loop_break_event <= 1'b0;
    end else begin
      if (minute_cnt >= MINUTE_CYCLES - 1) begin
        minute_cnt <= '0;
        if (minutes != 16'hffff) begin
          minutes <= minutes + 16'h1;
        end
      end else begin
        minute_cnt <= minute_cnt + 32'h1;
      end
      if (minutes >= loop_break_interval) begin
        loop_break_event <= 1'b1;
      end
    end
  end

  // output channel routing
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chan
      logic [2:0] sel;
      assign sel = chan_reg[c*CHAN_STRIDE +: CHAN_SEL_W];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          channel_out[c] <= 1'b0;
        end else begin
          case (sel)
            SRC_CONTROL: channel_out[c] <= ctrl_on;
            SRC_ALARM1:  channel_out[c] <= alarm_out[0];
            SRC_ALARM2:  channel_out[c] <= alarm_out[1];
            SRC_EITHER:  channel_out[c] <= |alarm_out;
            SRC_LOOPBRK: channel_out[c] <= loop_break_event;
            default:     channel_out[c] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // register reads
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = '0;
    case (araddr)
      CTRL_OFS:      rd_word = ctrl;
      MANUAL_MV_OFS: rd_word = {25'h0, manual_mv};
      SETPOINT_OFS:  rd_word = {16'h0, setpoint};
      PBAND_OFS:     rd_word = {16'h0, proportional_band};
      ITIME_OFS:     rd_word = {16'h0, integral_time};
      DTIME_OFS:     rd_word = {16'h0, derivative_time};
      RT_LOW_OFS:    rd_word = {16'h0, retrans_low_limit};
      RT_HIGH_OFS:   rd_word = {16'h0, retrans_high_limit};
      SAFE_OFS:      rd_word = {25'h0, sensor_fault_output_level};
      ALM1_SP_OFS:   rd_word = {16'h0, alarm_sp[0]};
      ALM2_SP_OFS:   rd_word = {16'h0, alarm_sp[1]};
      ALM_FUNC_OFS:  rd_word = alarm_func_reg;
      CHAN_OFS:      rd_word = chan_reg;
      LB_INT_OFS:    rd_word = {16'h0, loop_break_interval};
      STATUS_OFS: begin
        rd_word[1:0]                       = alarm_out;
        rd_word[2]                         = loop_break_event;
        rd_word[STAT_FAULT_BIT]            = fault;
        rd_word[STAT_ONOFF_BIT]            = auto_mode & onoff;
        rd_word[STAT_MV_LSB +: 7]          = mv_percent;
      end
      default:       rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      if (ar_hs) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
      arready <= ~(ar_hs | (rvalid & ~rready));
    end
  end

endmodule // ctrl_supervisor
`default_nettype wire

// ==== tb/supervisor_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module supervisor_props
  import ctrl_supervisor_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // process side
  input wire logic [15:0] proportional_band,
  input wire logic [6:0]  mv_percent,
  input wire logic [14:0] analog_ua
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_done; bvalid && bready; endsequence
  sequence rd_done; rvalid && rready; endsequence
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed");
  chk_bvalid_clear: assert property (wr_done |=> !bvalid)
    else $error("write answer repeated");
  chk_ar_reopen: assert property (rd_done |=> arready && !rvalid)
    else $error("read channel not reopened");
  chk_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  chk_aw_refuse: assert property (awvalid && awready |=> !awready)
    else $error("second write taken");
  chk_mv_limit: assert property (mv_percent <= MV_FULL)
    else $error("mv above full");
  chk_ua_limit: assert property (analog_ua <= UA_FULL)
    else $error("current above full");
  chk_band_write: assert property ($changed(proportional_band) |-> $rose(bvalid))
    else $error("band changed without write");
endmodule // supervisor_props
bind ctrl_supervisor supervisor_props props (.aclk, .aresetn, .awvalid, .awready, .bvalid,
  .bready, .bresp, .arready, .rvalid, .rready, .rdata, .proportional_band, .mv_percent,
  .analog_ua);
`default_nettype wire

// ==== tb/process_plant.sv ====
`timescale 1ns/1ps
`default_nettype none
module process_plant (
  // clock
  input wire logic               aclk,
  // demands from the bench
  input wire logic signed [15:0] pv_goal,
  input wire logic               fault_goal,
  input wire logic [6:0]         mv_goal,
  // towards the supervisor
  output var logic signed [15:0] pv = 16'sh0,
  output var logic               sensor_fault = 1'b0,
  output var logic [6:0]         pid_mv = 7'h00
);
  // a broken sensor reads garbage that changes every cycle
  always @(posedge aclk) begin
    pv <= fault_goal ? ~pv : pv_goal;
    sensor_fault <= fault_goal;
    pid_mv <= mv_goal;
  end
endmodule // process_plant
`default_nettype wire

// ==== tb/tb_control_output_alarm_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_control_output_alarm_supervisor import ctrl_supervisor_pkg::*; ();
  logic               aclk = 1'b0, aresetn = 1'b0, flt = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]        wdata = 32'h0, rdata;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid, sensor_fault, loop_break_event;
  logic [1:0]         bresp, rresp;
  logic signed [15:0] pv, pv_goal = 16'sh0;
  logic [6:0]         pid_mv, mid = 7'h00, mv_percent;
  logic [15:0]        proportional_band, integral_time, derivative_time;
  logic [3:0]         channel_out;
  logic [14:0]        analog_ua;
  int                 err_count = 0, tests_run = 0, i;
  logic [2:0]         tfn[9] = '{ALM_OFF, ALM_UNDER, ALM_UNDER, ALM_OVER, ALM_OVER, ALM_DEV,
                                 ALM_DEV, ALM_DEV_HIGH, ALM_DEV_HIGH};
  int                 tpv[9] = '{-50, 5, 20, 20, 5, 85, 95, 85, 115};
  bit                 tfl[9] = '{0, 0, 0, 0, 1, 0, 0, 0, 0};
  bit                 tex[9] = '{0, 1, 0, 1, 1, 1, 0, 0, 1};
  ctrl_supervisor #(.MINUTE_CYCLES(20), .STEP_CYCLES(2)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .pv, .pid_mv, .sensor_fault, .proportional_band, .integral_time, .derivative_time,
    .channel_out, .analog_ua, .mv_percent, .loop_break_event);
  process_plant plant (.aclk, .pv_goal, .fault_goal(flt), .mv_goal(mid), .pv, .sensor_fault,
    .pid_mv);
  initial forever #25 aclk = ~aclk;
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic st(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    @(posedge aclk);
    chk(n < 50 && bresp === er, "write");
    if (n == 50) conclude();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    @(posedge aclk);
    chk(n < 50 && rdata === e && rresp === er, "read");
    if (n == 50) conclude();
  endtask
  task automatic pc(input logic [6:0] m, input logic [14:0] u, input string s);
    st(6);
    chk(mv_percent === m && analog_ua === u, s);
  endtask
  function automatic logic [14:0] ua(input int m, input bit z);
    return z ? 15'(UA_FULL * m / MV_FULL)
             : 15'(UA_LIVE_ZERO + (UA_FULL - UA_LIVE_ZERO) * m / MV_FULL);
  endfunction
  initial begin
    st(16);
    aresetn <= 1'b1;
    st(2);
    rd(CTRL_OFS, CTRL_RESET, RESP_OKAY);
    rd(CHAN_OFS, CHAN_RESET, RESP_OKAY);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    wr(STATUS_OFS, 32'h0, RESP_SLVERR);
    $display("done: registers");
    wr(MANUAL_MV_OFS, 32'h32, RESP_OKAY);
    pc(7'h32, ua(50, 0), "manual");
    wr(CTRL_OFS, 32'h32, RESP_OKAY);
    pc(7'h32, ua(50, 1), "zero based");
    wr(MANUAL_MV_OFS, 32'h78, RESP_OKAY);
    pc(MV_FULL, UA_FULL, "clamp");
    chk(channel_out[0] === 1'b1, "control chan");
    wr(SETPOINT_OFS, 32'h64, RESP_OKAY);
    pv_goal <= 16'sh32;
    wr(CTRL_OFS, 32'h01, RESP_OKAY);
    pc(MV_FULL, UA_FULL, "on");
    pv_goal <= 16'sh96;
    pc(MV_NONE, UA_LIVE_ZERO, "off");
    chk(channel_out[0] === 1'b0, "off chan");
    flt <= 1'b1;
    wr(SAFE_OFS, 32'h28, RESP_OKAY);
    pc(MV_NONE, UA_LIVE_ZERO, "safe onoff");
    wr(SAFE_OFS, 32'h64, RESP_OKAY);
    pc(MV_FULL, UA_FULL, "safe full");
    wr(PBAND_OFS, 32'h05, RESP_OKAY);
    wr(SAFE_OFS, 32'h28, RESP_OKAY);
    pc(7'h28, ua(40, 0), "safe pid");
    flt <= 1'b0;
    mid <= 7'h25;
    pc(7'h25, ua(37, 0), "pid");
    wr(ITIME_OFS, 32'h1234, RESP_OKAY);
    wr(DTIME_OFS, 32'h0042, RESP_OKAY);
    st(2);
    chk(integral_time === 16'h1234 && proportional_band === 16'h5, "pid regs");
    chk(derivative_time === 16'h0042, "derivative reg");
    wr(RT_HIGH_OFS, 32'h3e8, RESP_OKAY);
    pv_goal <= 16'sh1f4;
    wr(CTRL_OFS, 32'h05, RESP_OKAY);
    pc(7'h25, ua(50, 0), "pv retrans");
    wr(CTRL_OFS, 32'h09, RESP_OKAY);
    pc(7'h25, ua(10, 0), "sp retrans");
    $display("done: outputs");
    wr(CHAN_OFS, 32'h4321, RESP_OKAY);
    wr(ALM1_SP_OFS, 32'h0a, RESP_OKAY);
    wr(ALM2_SP_OFS, 32'hc8, RESP_OKAY);
    wr(CTRL_OFS, 32'h01, RESP_OKAY);
    for (i = 0; i < 9; i++) begin
      pv_goal <= 16'(tpv[i]);
      flt <= tfl[i];
      wr(ALM_FUNC_OFS, {25'h0, ALM_OVER, 1'b0, tfn[i]}, RESP_OKAY);
      st(8);
      chk(channel_out[0] === tex[i], "alarm 1");
      chk(channel_out[2:1] === {tex[i] | tfl[i], tfl[i]}, "alarm 2");
    end
    pv_goal <= 16'sh5;
    wr(CTRL_OFS, 32'h11, RESP_OKAY);
    wr(ALM_FUNC_OFS, {29'h0, ALM_UNDER}, RESP_OKAY);
    st(8);
    chk(channel_out[0] === 1'b0, "blocked");
    pv_goal <= 16'sh14;
    st(8);
    pv_goal <= 16'sh5;
    st(8);
    chk(channel_out[0] === 1'b1, "armed");
    flt <= 1'b1;
    wr(ALM_FUNC_OFS, {29'h0, ALM_OPEN}, RESP_OKAY);
    st(8);
    chk(channel_out[0] === 1'b1, "open sensor");
    flt <= 1'b0;
    $display("done: alarms");
    mid <= MV_FULL;
    wr(CTRL_OFS, 32'h01, RESP_OKAY);
    st(60);
    chk(loop_break_event === 1'b0, "break disabled");
    wr(LB_INT_OFS, 32'h1, RESP_OKAY);
    for (i = 0; i < 200 && loop_break_event !== 1'b1; i++)
      st(1);
    st(2);
    chk(i < 200 && channel_out[3] === 1'b1, "break event");
    $display("done: loop break");
    conclude();
  end
endmodule // tb_control_output_alarm_supervisor
`default_nettype wire
